// file: src/artmr_pkg.sv
package artmr_pkg;
  // register byte offsets on the bus
  localparam logic [5:0] ADDR_CONTROL   = 6'h00;
  localparam logic [5:0] ADDR_CLOCK_CTL = 6'h04;
  localparam logic [5:0] ADDR_RELOAD_LO = 6'h08;
  localparam logic [5:0] ADDR_RELOAD_HI = 6'h0C;
  localparam logic [5:0] ADDR_COUNT_LO  = 6'h10;
  localparam logic [5:0] ADDR_COUNT_HI  = 6'h14;
  localparam logic [5:0] ADDR_IRQ_STAT  = 6'h18;
  localparam logic [5:0] ADDR_IRQ_MASK  = 6'h1C;
  // timer_control_reg fields
  localparam int BIT_HIGH_OVF   = 7;
  localparam int BIT_LOW_OVF    = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPT_EN    = 4;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_EXT_SEL    = 0;
  // clock_control_reg fields
  localparam int BIT_HI_CLK_SEL = 7;
  localparam int BIT_LO_CLK_SEL = 6;
  // interrupt status and mask fields
  localparam int BIT_IRQ_HIGH   = 0;
  localparam int BIT_IRQ_LOW    = 1;
  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_IRQ  = 2'h0;
  // clock dividers and counter full values
  localparam int          SYS_DIV      = 12;
  localparam logic [3:0]  SYS_DIV_LAST = 4'(SYS_DIV - 1);
  localparam logic [2:0]  EXT_DIV_RISE = 3'h3;
  localparam logic [2:0]  EXT_DIV_FALL = 3'h7;
  localparam logic [15:0] COUNT_FULL   = 16'hFFFF;
  localparam logic [7:0]  BYTE_FULL    = 8'hFF;
endpackage

// file: src/artmr_timer.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module artmr_timer
  import artmr_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clock_enable,
  input  wire logic        ext_osc,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);

  function automatic logic sel_tick(input logic sys_sel, input logic ext_sel,
                                    input logic div12, input logic ext8);
    sel_tick = sys_sel ? 1'b1 : (ext_sel ? ext8 : div12);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] cnt_lo_reg, cnt_hi_reg, rl_lo_reg, rl_hi_reg;
  logic       hf_reg, lf_reg, lbie_reg, capt_reg, split_reg, run_reg, xsel_reg;
  logic       hsel_reg, lsel_reg;
  logic [1:0] stat_reg, mask_reg;
  logic [3:0] div12_reg;
  logic [2:0] ext_div_reg;
  logic       ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_lvl_reg;
  logic       wait_reg, irq_reg;
  logic [31:0] rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // bus decode: one wait cycle, then a one-cycle accept
  wire req     = avs_read | avs_write;
  wire wr_en   = avs_write & ~wait_reg & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  wire wr_ctl  = wr_en & (avs_address == ADDR_CONTROL);
  wire wr_ck   = wr_en & (avs_address == ADDR_CLOCK_CTL);
  wire wr_rll  = wr_en & (avs_address == ADDR_RELOAD_LO);
  wire wr_rlh  = wr_en & (avs_address == ADDR_RELOAD_HI);
  wire wr_cl   = wr_en & (avs_address == ADDR_COUNT_LO);
  wire wr_ch   = wr_en & (avs_address == ADDR_COUNT_HI);
  wire wr_st   = wr_en & (avs_address == ADDR_IRQ_STAT);
  wire wr_mk   = wr_en & (avs_address == ADDR_IRQ_MASK);
  wire wait_next = ~(req & wait_reg);

  wire [7:0] ctl_val = {hf_reg, lf_reg, lbie_reg, capt_reg, split_reg, run_reg,
                        1'b0, xsel_reg};
  wire [7:0] ck_val  = {hsel_reg, lsel_reg, 6'h00};
  // unmapped offsets read as zero and ignore writes
  wire [7:0] rd_byte =
    (avs_address == ADDR_CONTROL)   ? ctl_val :
    (avs_address == ADDR_CLOCK_CTL) ? ck_val :
    (avs_address == ADDR_RELOAD_LO) ? rl_lo_reg :
    (avs_address == ADDR_RELOAD_HI) ? rl_hi_reg :
    (avs_address == ADDR_COUNT_LO)  ? cnt_lo_reg :
    (avs_address == ADDR_COUNT_HI)  ? cnt_hi_reg :
    (avs_address == ADDR_IRQ_STAT)  ? {6'h00, stat_reg} :
    (avs_address == ADDR_IRQ_MASK)  ? {6'h00, mask_reg} : 8'h00;
  wire [31:0] rdata_next = (avs_read & wait_reg) ? {24'h000000, rd_byte} : rdata_reg;

  //////////////////////////////////////////////////////////////////////////////
  // count clocks
  wire div12_tick = (div12_reg == SYS_DIV_LAST);
  wire [3:0] div12_next = div12_tick ? 4'h0 : div12_reg + 4'h1;
  // the filtered level moves only once the two later sync stages agree
  wire ext_agree = (ext_s2_reg == ext_s3_reg);
  wire ext_rise  = ext_agree & ext_s3_reg & ~ext_lvl_reg;
  // one /8 period spans eight filtered rising edges of the pin
  wire ext_tick  = ext_rise & (ext_div_reg == EXT_DIV_RISE);
  wire ext_fall  = ext_rise & (ext_div_reg == EXT_DIV_FALL);
  wire [2:0] ext_div_next = ext_rise ? ext_div_reg + 3'h1 : ext_div_reg;
  wire lo_tick  = sel_tick(lsel_reg, xsel_reg, div12_tick, ext_tick);
  wire hi_tick  = sel_tick(hsel_reg, xsel_reg, div12_tick, ext_tick);
  // capture measures the external clock, so it cannot also count it
  wire cap_tick = lsel_reg | div12_tick;

  //////////////////////////////////////////////////////////////////////////////
  // counter
  wire [15:0] cnt = {cnt_hi_reg, cnt_lo_reg};
  wire [15:0] rl  = {rl_hi_reg, rl_lo_reg};
  wire t16     = ~split_reg & run_reg & (capt_reg ? cap_tick : lo_tick);
  wire ovf16   = t16 & (cnt == COUNT_FULL);
  wire cap_evt = capt_reg & ext_fall;
  // reload registers hold captured values in capture mode, so wrap to zero
  wire [15:0] auto16 = (ovf16 & ~capt_reg) ? rl : cnt + 16'h0001;
  wire lo_run  = split_reg ? lo_tick : t16;
  wire hi_run  = split_reg ? (run_reg & hi_tick) : t16;
  wire lo_wrap = lo_run & (cnt_lo_reg == BYTE_FULL);
  wire hi_wrap = split_reg & hi_run & (cnt_hi_reg == BYTE_FULL);
  wire [7:0] lo_auto = split_reg ? (lo_wrap ? rl_lo_reg : cnt_lo_reg + 8'h01)
                                 : auto16[7:0];
  wire [7:0] hi_auto = split_reg ? (hi_wrap ? rl_hi_reg : cnt_hi_reg + 8'h01)
                                 : auto16[15:8];
  wire [7:0] cnt_lo_next = wr_cl ? wd : (lo_run ? lo_auto : cnt_lo_reg);
  wire [7:0] cnt_hi_next = wr_ch ? wd : (hi_run ? hi_auto : cnt_hi_reg);
  // a capture beats a software write to the same reload byte
  wire [7:0] rl_lo_next = cap_evt ? cnt_lo_reg : (wr_rll ? wd : rl_lo_reg);
  wire [7:0] rl_hi_next = cap_evt ? cnt_hi_reg : (wr_rlh ? wd : rl_hi_reg);

  //////////////////////////////////////////////////////////////////////////////
  // flags: a hardware set wins over a software clear in the same cycle
  wire hf_set  = ovf16 | hi_wrap | cap_evt;
  wire lf_set  = lo_wrap;
  wire hf_next = hf_set | (wr_ctl ? wd[BIT_HIGH_OVF] : hf_reg);
  wire lf_next = lf_set | (wr_ctl ? wd[BIT_LOW_OVF] : lf_reg);
  wire [1:0] stat_set  = {lf_set & lbie_reg, hf_set};
  wire [1:0] stat_next = stat_set | (stat_reg & ~(wr_st ? wd[1:0] : 2'h0));
  // mask bit 0 is the timer interrupt enable; the low source needs it too
  wire irq_next = mask_reg[BIT_IRQ_HIGH] &
                  (stat_reg[BIT_IRQ_HIGH] |
                   (stat_reg[BIT_IRQ_LOW] & mask_reg[BIT_IRQ_LOW]));

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      {cnt_lo_reg, cnt_hi_reg, rl_lo_reg, rl_hi_reg} <= {4{RESET_BYTE}};
      {hf_reg, lf_reg, lbie_reg, capt_reg} <= 4'h0;
      {split_reg, run_reg, xsel_reg, hsel_reg, lsel_reg} <= 5'h00;
    end
    else if (clock_enable)
    begin
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      rl_lo_reg  <= rl_lo_next;
      rl_hi_reg  <= rl_hi_next;
      hf_reg     <= hf_next;
      lf_reg     <= lf_next;
      if (wr_ctl)
      begin
        lbie_reg  <= wd[BIT_LOW_IRQ_EN];
        capt_reg  <= wd[BIT_CAPT_EN];
        split_reg <= wd[BIT_SPLIT];
        run_reg   <= wd[BIT_RUN];
        xsel_reg  <= wd[BIT_EXT_SEL];
      end
      if (wr_ck)
      begin
        hsel_reg <= wd[BIT_HI_CLK_SEL];
        lsel_reg <= wd[BIT_LO_CLK_SEL];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      {stat_reg, mask_reg} <= {RESET_IRQ, RESET_IRQ};
      {div12_reg, ext_div_reg} <= 7'h00;
      {ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_lvl_reg} <= 4'h0;
      wait_reg  <= 1'b1;
      irq_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end
    else if (clock_enable)
    begin
      stat_reg    <= stat_next;
      mask_reg    <= wr_mk ? wd[1:0] : mask_reg;
      div12_reg   <= div12_next;
      ext_s1_reg  <= ext_osc;
      ext_s2_reg  <= ext_s1_reg;
      ext_s3_reg  <= ext_s2_reg;
      ext_lvl_reg <= ext_agree ? ext_s3_reg : ext_lvl_reg;
      ext_div_reg <= ext_div_next;
      wait_reg    <= wait_next;
      irq_reg     <= irq_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq             = irq_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  wire cnt_sw = wr_cl | wr_ch;

  AST_OVF16_RELOAD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && ovf16 && !capt_reg && !cnt_sw
    |=> cnt == $past(rl) && hf_reg)
    else $error("16-bit overflow did not reload or set high flag");

  AST_LOW_WRAP_IRQ: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !split_reg && lo_wrap && lbie_reg
    |=> stat_reg[BIT_IRQ_LOW] && lf_reg)
    else $error("low wrap with low enable did not raise low source");

  AST_IRQ_OUT: assert property (@(posedge clock) disable iff (reset)
    clock_enable && stat_reg[BIT_IRQ_HIGH] && mask_reg[BIT_IRQ_HIGH] |=> irq)
    else $error("pending unmasked overflow did not raise irq");

  AST_NO_IRQ_MASKED: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !mask_reg[BIT_IRQ_HIGH] |=> !irq)
    else $error("irq raised with timer interrupt disabled");

  AST_SPLIT_LO_RELOAD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && split_reg && lo_wrap && !wr_cl
    |=> cnt_lo_reg == $past(rl_lo_reg) && lf_reg)
    else $error("split low byte did not reload from its reload byte");

  AST_SPLIT_HI_HELD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && split_reg && !run_reg && !wr_ch |=> $stable(cnt_hi_reg))
    else $error("split high byte moved while stopped");

  AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (reset)
    hf_reg && !wr_ctl |=> hf_reg)
    else $error("high overflow flag cleared without a write");

  AST_CAPTURE: assert property (@(posedge clock) disable iff (reset)
    clock_enable && cap_evt |=> rl == $past(cnt) && hf_reg)
    else $error("capture did not copy the count");

  AST_CAPT_KEEPS_RUN: assert property (@(posedge clock) disable iff (reset)
    clock_enable && cap_evt && t16 && !cnt_sw && cnt != COUNT_FULL
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("count disturbed by capture");

  //////////////////////////////////////////////////////////////////////////////
  // split reloads, flags, clock selection, capture gating, interrupt sources and bus handshake
  AST_SPLIT_HI_RELOAD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && hi_wrap && !wr_ch
    |=> cnt_hi_reg == $past(rl_hi_reg) && hf_reg)
    else $error("split high byte did not reload or set high flag");

  AST_LOW_FLAG: assert property (@(posedge clock) disable iff (reset)
    clock_enable && lo_wrap |=> lf_reg)
    else $error("low byte wrap did not set low flag");

  AST_SPLIT_LO_FREE: assert property (@(posedge clock) disable iff (reset)
    clock_enable && split_reg && !run_reg && lo_tick && !wr_cl && cnt_lo_reg != BYTE_FULL
    |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("split low byte stopped with run control off");

  // outside a capture only a bus write may move a reload byte
  AST_CAPT_ONLY_FALL: assert property (@(posedge clock) disable iff (reset)
    clock_enable && capt_reg && !ext_fall && !wr_rll |=> rl_lo_reg == $past(rl_lo_reg))
    else $error("reload low byte moved without a capture event");

  AST_NO_CAPT_OFF: assert property (@(posedge clock) disable iff (reset)
    clock_enable && !capt_reg && !wr_rlh |=> rl_hi_reg == $past(rl_hi_reg))
    else $error("reload high byte moved with capture mode off");

  AST_CAPT_SYS_CLOCK: assert property (@(posedge clock) disable iff (reset)
    clock_enable && capt_reg && !split_reg && run_reg && lsel_reg
    && !cnt_sw && cnt != COUNT_FULL
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("capture count did not follow the system clock");

  AST_EXT_CLOCK: assert property (@(posedge clock) disable iff (reset)
    clock_enable && split_reg && !lsel_reg && xsel_reg && !ext_tick && !wr_cl
    |=> $stable(cnt_lo_reg))
    else $error("low byte moved between external clock ticks");

  AST_DIV12_CLOCK: assert property (@(posedge clock) disable iff (reset)
    clock_enable && split_reg && !lsel_reg && !xsel_reg && !div12_tick && !wr_cl
    |=> $stable(cnt_lo_reg))
    else $error("low byte moved between divided clock ticks");

  AST_IRQ_LOW_SRC: assert property (@(posedge clock) disable iff (reset)
    clock_enable && stat_reg[BIT_IRQ_LOW] && mask_reg[BIT_IRQ_HIGH] && mask_reg[BIT_IRQ_LOW]
    |=> irq)
    else $error("pending unmasked low source did not raise irq");

  AST_STAT_STICKY: assert property (@(posedge clock) disable iff (reset)
    clock_enable && stat_reg[BIT_IRQ_HIGH] && !wr_st |=> stat_reg[BIT_IRQ_HIGH])
    else $error("high interrupt source cleared without a write");

  AST_DIV12_PERIOD: assert property (@(posedge clock) disable iff (reset)
    clock_enable && div12_tick |=> div12_reg == 4'h0)
    else $error("system clock divider did not restart");

  AST_BUS_ACCEPT: assert property (@(posedge clock) disable iff (reset)
    clock_enable && req && wait_reg |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus request not accepted after one wait cycle");

endmodule

// file: test/artmr_osc_model.sv
`timescale 1ns/1ps
module artmr_osc_model #(
  parameter int HALF_NS = 40
) (
  output logic osc
);
  // free-running source, offset so its edges never meet the system clock edges
  initial
  begin
    osc = 1'b0;
    #3;
    forever #(HALF_NS) osc = ~osc;
  end
endmodule

// file: test/artmr_timer_test.sv
`timescale 1ns/1ps
module artmr_timer_test import artmr_pkg::*; ;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } artmr_row_s;
  logic        clock;
  logic        reset;
  logic        ext_osc;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  int          error_cnt;
  int          tests_run;
  logic [31:0] rd;
  logic [15:0] cap_a;
  artmr_row_s  rows [9] = '{'{ADDR_RELOAD_LO, 8'h5A, 8'h5A}, '{ADDR_RELOAD_HI, 8'hA5, 8'hA5},
    '{ADDR_COUNT_LO, 8'h3C, 8'h3C}, '{ADDR_COUNT_HI, 8'hC3, 8'hC3},
    '{ADDR_CLOCK_CTL, 8'hC0, 8'hC0}, '{ADDR_CONTROL, 8'h02, 8'h00},
    '{ADDR_IRQ_MASK, 8'h02, 8'h02}, '{ADDR_IRQ_STAT, 8'h03, 8'h00}, '{6'h20, 8'hFF, 8'h00}};
  artmr_timer dut_u (
    .clock           (clock),
    .reset           (reset),
    .clock_enable    (1'b1),
    .ext_osc         (ext_osc),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq             (irq)
  );
  // half period of 4 clocks gives a 64-clock capture period, slow against the count clock
  artmr_osc_model #(.HALF_NS(40)) osc_u (.osc (ext_osc));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one transfer; request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] addr, input logic [7:0] data);
    int n;
    n = 0;
    @(posedge clock);
    avs_read      <= ~wr;
    avs_write     <= wr;
    avs_address   <= addr;
    avs_writedata <= {24'h000000, data};
    do
    begin
      @(posedge clock);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic wr(input logic [5:0] addr, input logic [7:0] data);
    bus(1'b1, addr, data);
  endtask
  task automatic rdm(input logic [5:0] addr, input logic [7:0] mask, input logic [7:0] exp);
    bus(1'b0, addr, 8'h00);
    chk(rd & {24'h000000, mask}, {24'h000000, exp});
  endtask
  task automatic poll(input logic [5:0] addr, input logic [7:0] mask);
    int n;
    n = 0;
    do
    begin
      bus(1'b0, addr, 8'h00);
      n++;
    end
    while ((rd[7:0] & mask) == 8'h00 && n < 100);
    chk(rd & {24'h000000, mask}, {24'h000000, mask});
    if ((rd[7:0] & mask) == 8'h00)
      wrap_up();
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
    if (irq !== 1'b1)
      wrap_up();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial
  begin
    {reset, avs_read, avs_write, avs_address, avs_writedata} = {1'b1, 40'h0};
    avs_byteenable = 4'hF;
    error_cnt = 0;
    tests_run = 0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) rdm(6'(a * 4), 8'hFF, 8'h00);
    $display("test reset values done");
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata);
      rdm(rows[i].addr, 8'hFF, rows[i].exp);
    end
    $display("test register rows done");
    wr(ADDR_RELOAD_HI, 8'h12);
    wr(ADDR_RELOAD_LO, 8'h34);
    wr(ADDR_COUNT_HI, 8'hFF);
    wr(ADDR_COUNT_LO, 8'hF0);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_CONTROL, 8'h04);
    wait_irq(60);
    rdm(ADDR_CONTROL, 8'h80, 8'h80);
    rdm(ADDR_COUNT_HI, 8'hFF, 8'h12);
    rdm(ADDR_CONTROL, 8'h80, 8'h80);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    $display("test 16-bit overflow done");
    wr(ADDR_COUNT_HI, 8'h00);
    wr(ADDR_COUNT_LO, 8'hF8);
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_CONTROL, 8'h24);
    wait_irq(60);
    rdm(ADDR_IRQ_STAT, 8'h03, 8'h02);
    rdm(ADDR_CONTROL, 8'hC0, 8'h40);
    wr(ADDR_CONTROL, 8'h00);
    wr(ADDR_IRQ_STAT, 8'h03);
    $display("test low-byte interrupt done");
    wr(ADDR_RELOAD_LO, 8'hF0);
    wr(ADDR_COUNT_HI, 8'h40);
    wr(ADDR_COUNT_LO, 8'hFA);
    wr(ADDR_CONTROL, 8'h08);
    poll(ADDR_CONTROL, 8'h40);
    rdm(ADDR_COUNT_LO, 8'hF0, 8'hF0);
    rdm(ADDR_COUNT_HI, 8'hFF, 8'h40);
    wr(ADDR_CLOCK_CTL, 8'h40);
    wr(ADDR_RELOAD_HI, 8'h77);
    wr(ADDR_COUNT_HI, 8'hFE);
    wr(ADDR_CONTROL, 8'h0C);
    wait_irq(100);
    rdm(ADDR_CONTROL, 8'h80, 8'h80);
    wr(ADDR_CONTROL, 8'h08);
    rdm(ADDR_COUNT_HI, 8'hF0, 8'h70);
    wr(ADDR_IRQ_STAT, 8'h03);
    $display("test split mode done");
    wr(ADDR_CLOCK_CTL, 8'h00);
    wr(ADDR_CONTROL, 8'h09);
    wr(ADDR_COUNT_LO, 8'h00);
    repeat (290) @(posedge clock);
    rdm(ADDR_COUNT_LO, 8'hFE, 8'h04);
    wr(ADDR_CONTROL, 8'h08);
    wr(ADDR_COUNT_LO, 8'h00);
    repeat (290) @(posedge clock);
    rdm(ADDR_COUNT_LO, 8'hFE, 8'h18);
    wr(ADDR_CLOCK_CTL, 8'h40);
    $display("test clock select done");
    wr(ADDR_COUNT_HI, 8'h00);
    wr(ADDR_COUNT_LO, 8'h00);
    wr(ADDR_CONTROL, 8'h14);
    poll(ADDR_CONTROL, 8'h80);
    rdm(ADDR_RELOAD_LO, 8'h80, 8'h00);
    cap_a[7:0] = rd[7:0];
    rdm(ADDR_RELOAD_HI, 8'hFF, 8'h00);
    cap_a[15:8] = rd[7:0];
    wr(ADDR_CONTROL, 8'h14);
    poll(ADDR_CONTROL, 8'h80);
    rdm(ADDR_RELOAD_HI, 8'hFF, 8'(cap_a[15:8] + (cap_a[7:0] >= 8'hC0)));
    rdm(ADDR_RELOAD_LO, 8'hFF, 8'(cap_a[7:0] + 8'h40));
    $display("test capture done");
    reset <= 1'b1;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    rdm(ADDR_CONTROL, 8'hFF, 8'h00);
    rdm(ADDR_COUNT_LO, 8'hFF, 8'h00);
    chk({31'h0, irq}, 32'h0);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule
